// ---- hdl/sps_defines.svh ----
// timing counts and data layout constants for the converter sequencer
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_CLK_MHZ 40
`define SPS_RES_BITS 14
`define SPS_BYTE_BITS 8
`define SPS_TCONV_NS 4700
// longest time rounds down
`define SPS_TCONV_CYC ((`SPS_TCONV_NS * `SPS_CLK_MHZ) / 1000)
// internal conversion clock divider, one step per this many cycles
`define SPS_STEP_DIV 8
`endif

// ---- hdl/sps_pkg.sv ----
// types shared by the converter sequencer modules
package sps_pkg;
	typedef enum logic [2:0] {
		SPS_IDLE,
		SPS_ACQ,
		SPS_CONV,
		SPS_DONE,
		SPS_READ
	} sps_state_type;
	typedef enum logic {
		SPS_STANDBY,
		SPS_SHUTDOWN
	} sps_pmode_type;
endpackage

// ---- hdl/sps_sar_if.sv ----
// handshake between sequencer and approximation engine
`timescale 1ns/1ps
interface sps_sar_if #(parameter int RES_BITS = 14);
	logic start;
	logic cmp;
	logic busy;
	logic done;
	logic [RES_BITS-1:0] trial;
	logic [RES_BITS-1:0] result;
	modport seq (output start, input busy, input done, input trial, input result);
	modport eng (input start, input cmp, output busy, output done, output trial, output result);
endinterface

// ---- hdl/sps_sar_engine.sv ----
// successive-approximation engine stepped by an internal divider
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_sar_engine
	import sps_pkg::*;
#(
	parameter int RES_BITS = `SPS_RES_BITS,
	parameter int STEP_DIV = `SPS_STEP_DIV
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// engine side of the link
	sps_sar_if.eng sar
);
	logic [7:0] div;
	logic [RES_BITS-1:0] trial;
	logic [RES_BITS-1:0] bitpos;
	logic busy;
	logic done;
	logic [7:0] next_div;
	logic [RES_BITS-1:0] next_trial;
	logic [RES_BITS-1:0] next_bitpos;
	logic next_busy;
	logic next_done;
	logic step;

	assign step = (div == 8'(STEP_DIV - 1));

	always_comb
	begin
		next_div = div;
		next_trial = trial;
		next_bitpos = bitpos;
		next_busy = busy;
		next_done = 1'b0;
		if (sar.start)
		begin
			next_busy = 1'b1;
			next_div = 8'h00;
			next_bitpos = {1'b1, {(RES_BITS-1){1'b0}}};
			next_trial = {1'b1, {(RES_BITS-1){1'b0}}};
		end
		else if (busy)
		begin
			// own clock, the host supplies none
			next_div = step ? 8'h00 : div + 8'h01;
			if (step)
			begin
				// keep bit if comparator says input is at or above trial
				next_trial = sar.cmp ? trial : (trial & ~bitpos);
				next_trial = next_trial | (bitpos >> 1);
				next_bitpos = bitpos >> 1;
				if (bitpos[0])
				begin
					next_busy = 1'b0;
					next_done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			div <= 8'h00;
			trial <= '0;
			bitpos <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			div <= next_div;
			trial <= next_trial;
			bitpos <= next_bitpos;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign sar.trial = trial;
	assign sar.result = trial;
	assign sar.busy = busy;
	assign sar.done = done;
endmodule // sps_sar_engine

// ---- hdl/sps_sequencer.sv ----
// strobe-edge sequencer with byte-wide three-state result port
// How it works
// - upper_byte_sel high drives the high result byte, low drives the low byte.
// - first strobe fall with select low powers up and starts acquisition.
// - second strobe fall holds the sample and starts the conversion.
// - third strobe fall with select high puts the result on the data pins.
// - select level at the second fall is kept as power-mode choice.
// - after each conversion enter chosen mode; shutdown turns reference and buffer off.
// - conversion completes and done asserts within 4.7 us of the second fall.
// - conversion clock is generated internally, no host clock needed.
// - each held sample yields a 14-bit result.
// - data pins are three-state, lowest low-byte pin carries the result LSB.
// - done output goes low when a conversion finishes.
// - select high at second fall picks shutdown, low picks standby.
// - upper byte carries zeros in its two top positions.
// - strobe rising after readout releases the data pins.
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_sequencer
	import sps_pkg::*;
#(
	parameter int RES_BITS = `SPS_RES_BITS,
	parameter int STEP_DIV = `SPS_STEP_DIV
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host bus controls
	input wire logic cycle_strobe_n,
	input wire logic read_conv_sel,
	input wire logic upper_byte_sel,
	// comparator from the analog core
	input wire logic cmp_above,
	// host bus data and status
	output logic [7:0] data_out,
	output logic data_oe,
	output logic done_n,
	// analog core controls
	output logic core_powered,
	output logic ref_powered,
	output logic track,
	output logic [RES_BITS-1:0] dac_code
);
	sps_sar_if #(.RES_BITS(RES_BITS)) sar ();

	sps_sar_engine #(
		.RES_BITS(RES_BITS),
		.STEP_DIV(STEP_DIV)
	) u_engine (
		.clk(clk),
		.rst(rst),
		.sar(sar)
	);

	// cycles allowed from the hold edge to done showing on the pin
	localparam int CONV_CYC = `SPS_TCONV_CYC;
	localparam int CNT_W = $clog2(CONV_CYC + 1);
	// done register and the next sample each cost a cycle after the count
	localparam int LATE_CYC = CONV_CYC - 2;

	function automatic logic [7:0] pick_byte(input logic [RES_BITS-1:0] r, input logic hi);
		logic [15:0] w;
		w = 16'(r);
		// top two bits of the upper byte always zero
		pick_byte = hi ? {2'b00, w[13:8]} : w[7:0];
	endfunction

	sps_state_type state;
	sps_state_type next_state;
	sps_pmode_type pmode;
	sps_pmode_type next_pmode;
	logic strobe_q;
	logic [RES_BITS-1:0] result;
	logic [RES_BITS-1:0] next_result;
	logic done_q;
	logic next_done_q;
	logic powered;
	logic next_powered;
	logic refon;
	logic next_refon;
	logic [7:0] dout;
	logic [7:0] next_dout;
	logic oe;
	logic next_oe;
	logic fall;
	logic rise;
	logic start;
	logic [CNT_W-1:0] conv_cnt;
	logic [CNT_W-1:0] next_conv_cnt;
	logic conv_late;

	// strobe taken as synchronous, edges found against last sample
	assign fall = strobe_q & ~cycle_strobe_n;
	assign rise = ~strobe_q & cycle_strobe_n;

	always_comb
	begin
		next_state = state;
		next_pmode = pmode;
		next_result = result;
		next_done_q = done_q;
		next_powered = powered;
		next_refon = refon;
		next_dout = dout;
		next_oe = oe;
		start = 1'b0;
		unique case (state)
			SPS_IDLE:
			begin
				// a first fall with select high is ignored
				if (fall && !read_conv_sel)
				begin
					next_state = SPS_ACQ;
					next_powered = 1'b1;
					next_refon = 1'b1;
					next_done_q = 1'b0;
				end
			end
			SPS_ACQ:
			begin
				if (fall)
				begin
					start = 1'b1;
					next_state = SPS_CONV;
					next_pmode = read_conv_sel ? SPS_SHUTDOWN : SPS_STANDBY;
				end
			end
			SPS_CONV:
			begin
				// a too slow divider setting ends early, keeping the deadline
				if (sar.done || conv_late)
				begin
					next_result = sar.result;
					next_done_q = 1'b1;
					next_state = SPS_DONE;
					// drop to the chosen power mode on our own
					next_powered = 1'b0;
					next_refon = (pmode == SPS_STANDBY);
				end
			end
			SPS_DONE:
			begin
				// host waits for done before this fall
				if (fall && read_conv_sel)
				begin
					next_state = SPS_READ;
					next_oe = 1'b1;
					next_dout = pick_byte(result, upper_byte_sel);
				end
			end
			SPS_READ:
			begin
				// byte follows the select while the strobe is low
				next_dout = pick_byte(result, upper_byte_sel);
				if (rise)
				begin
					next_oe = 1'b0;
					next_done_q = 1'b0;
					next_state = SPS_IDLE;
				end
			end
			default:
			begin
				next_state = SPS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= SPS_IDLE;
			pmode <= SPS_STANDBY;
			strobe_q <= 1'b1;
			result <= '0;
			done_q <= 1'b0;
			powered <= 1'b0;
			refon <= 1'b0;
			dout <= 8'h00;
			oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			pmode <= next_pmode;
			strobe_q <= cycle_strobe_n;
			result <= next_result;
			done_q <= next_done_q;
			powered <= next_powered;
			refon <= next_refon;
			dout <= next_dout;
			oe <= next_oe;
		end
	end

	// converting cycles since the hold edge; stops at the last safe count
	assign conv_late = (conv_cnt == CNT_W'(LATE_CYC));

	always_comb
	begin
		next_conv_cnt = '0;
		if (state == SPS_CONV && conv_late)
			next_conv_cnt = conv_cnt;
		else if (state == SPS_CONV)
			next_conv_cnt = conv_cnt + CNT_W'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			conv_cnt <= '0;
		else
			conv_cnt <= next_conv_cnt;
	end

	assign sar.start = start;
	assign sar.cmp = cmp_above;
	assign data_out = dout;
	assign data_oe = oe;
	assign done_n = ~done_q;
	assign core_powered = powered | (state == SPS_CONV);
	assign ref_powered = refon | (state == SPS_CONV);
	assign track = (state == SPS_ACQ);
	assign dac_code = sar.trial;
endmodule // sps_sequencer

// ---- testbench/sps_analog_model.sv ----
// hold capacitor and comparator model of the analog core
`timescale 1ns/1ps
module sps_analog_model (
	// core side
	input wire logic clk,
	input wire logic track,
	input wire logic [13:0] vin,
	input wire logic [13:0] dac_code,
	output logic cmp_above
);
	logic [13:0] held = 14'h0000;
	// sample freezes when tracking ends
	always @(posedge clk)
		if (track)
			held <= vin;
	assign cmp_above = held >= dac_code;
endmodule // sps_analog_model

// ---- testbench/sps_seq_chk.sv ----
// port checks on the converter sequencer
`timescale 1ns/1ps
module sps_seq_chk (
	// host side
	input wire logic clk,
	input wire logic rst,
	input wire logic cycle_strobe_n,
	input wire logic read_conv_sel,
	input wire logic upper_byte_sel,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic done_n,
	// core side
	input wire logic core_powered,
	input wire logic ref_powered,
	input wire logic track
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic prev_n;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			prev_n <= 1'b1;
		else
			prev_n <= cycle_strobe_n;
	a_acq_power: assert property (track |-> core_powered && ref_powered && !data_oe)
		else $error("acquire state wrong");
	a_hold_start: assert property (track && !cycle_strobe_n && prev_n |=> !track)
		else $error("hold missed");
	// track falls one cycle after the hold edge, so the window ends one short
	a_conv_time: assert property ($fell(track) |-> ##[100:187] !done_n)
		else $error("done late");
	a_mode_off: assert property (track && !cycle_strobe_n && prev_n && read_conv_sel
		|-> ##[100:190] (!done_n && !ref_powered))
		else $error("shutdown missed");
	a_mode_on: assert property (track && !cycle_strobe_n && prev_n && !read_conv_sel
		|-> ##[100:190] (!done_n && ref_powered))
		else $error("standby missed");
	a_out_cause: assert property ($rose(data_oe)
		|-> !done_n && !$past(cycle_strobe_n) && $past(read_conv_sel))
		else $error("bus driven early");
	a_high_zero: assert property (data_oe && $past(upper_byte_sel)
		|-> data_out[7:6] == 2'b00)
		else $error("upper bits set");
	a_bus_release: assert property (data_oe && cycle_strobe_n |=> !data_oe && done_n)
		else $error("bus kept");
endmodule // sps_seq_chk
bind sps_sequencer sps_seq_chk u_sps_seq_chk (.clk(clk), .rst(rst),
	.cycle_strobe_n(cycle_strobe_n), .read_conv_sel(read_conv_sel),
	.upper_byte_sel(upper_byte_sel), .data_out(data_out), .data_oe(data_oe),
	.done_n(done_n), .core_powered(core_powered), .ref_powered(ref_powered), .track(track));

// ---- testbench/sar_adc_parallel_sequencer_bench.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_parallel_sequencer_bench;
	logic clk = 0, rst = 1, cs_n = 1, sel = 0, ube = 0, cmp, oe, done_n, core, refp, trk;
	logic [7:0] dout;
	logic [13:0] dac, vin = 14'h0000;
	int error_cnt = 0, tests_run = 0, n;
	logic [13:0] vals [4] = '{14'h3fff, 14'h0000, 14'h2a5c, 14'h1001};
	always #12.5 clk = ~clk;
	sps_sequencer u_sps_sequencer (.clk(clk), .rst(rst), .cycle_strobe_n(cs_n),
		.read_conv_sel(sel), .upper_byte_sel(ube), .cmp_above(cmp), .data_out(dout),
		.data_oe(oe), .done_n(done_n), .core_powered(core), .ref_powered(refp),
		.track(trk), .dac_code(dac));
	sps_analog_model u_sps_analog_model (.clk(clk), .track(trk), .vin(vin),
		.dac_code(dac), .cmp_above(cmp));
	task chk(input logic [13:0] got, input logic [13:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// strobe, select and byte change together, then two cycles to settle
	task edge_to(input logic s, input logic r, input logic u);
		@(negedge clk);
		cs_n = s;
		sel = r;
		ube = u;
		repeat (2) @(negedge clk);
	endtask
	task stop_test;
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 0;
		edge_to(0, 1, 0);
		chk(trk, 0);
		edge_to(1, 0, 0);
		for (int i = 0; i < 4; i++)
		begin
			vin = vals[i];
			edge_to(0, 0, 0);
			chk({core, refp, trk}, 3'h7);
			edge_to(1, 0, 0);
			edge_to(0, i[0], 0);
			chk({trk, oe}, 0);
			edge_to(1, 0, 0);
			edge_to(0, 0, 0);
			chk(trk, 0);
			n = 8;
			// host holds off the readout fall until done shows
			while (done_n !== 1'b0 && n < 200)
			begin
				@(negedge clk);
				n++;
			end
			chk(n <= 188, 1);
			chk(dac, vals[i]);
			edge_to(1, 1, 0);
			edge_to(0, 0, 0);
			chk(oe, 0);
			edge_to(1, 1, 1);
			chk({core, refp}, {1'b0, ~i[0]});
			edge_to(0, 1, 1);
			chk(dout, {2'b00, vals[i][13:8]});
			edge_to(0, 1, 0);
			chk(dout, vals[i][7:0]);
			edge_to(1, 0, 0);
			chk({oe, done_n}, 2'h1);
		end
		stop_test();
	end
	initial
	begin
		// four conversions need about 15 us
		#100us;
		error_cnt++;
		stop_test();
	end
endmodule // sar_adc_parallel_sequencer_bench
